// [lsr_defs.svh]
// Register offsets, field widths, reset values and timing counts of the LED status register bank.
`ifndef LSR_DEFS_SVH
`define LSR_DEFS_SVH

// Register byte offsets.
`define LSR_ADDR_EN_HI 8'h00
`define LSR_ADDR_EN_LO 8'h01
`define LSR_ADDR_SINK8 8'h2d
`define LSR_ADDR_SINK9 8'h2e
`define LSR_ADDR_SINK10 8'h2f
`define LSR_ADDR_GEN_HI 8'h30
`define LSR_ADDR_GEN_LO 8'h31
`define LSR_ADDR_BAND_HI 8'h32
`define LSR_ADDR_BAND_LO 8'h33
`define LSR_ADDR_GND_HI 8'h34
`define LSR_ADDR_GND_LO 8'h35
`define LSR_ADDR_STR_HI 8'h36
`define LSR_ADDR_STR_LO 8'h37
`define LSR_ADDR_HGEN_HI 8'h38
`define LSR_ADDR_HGEN_LO 8'h39
`define LSR_ADDR_HBAND_HI 8'h3a
`define LSR_ADDR_HBAND_LO 8'h3b
`define LSR_ADDR_HGND_HI 8'h3c
`define LSR_ADDR_HGND_LO 8'h3d
`define LSR_ADDR_HSTR_HI 8'h3e
`define LSR_ADDR_HSTR_LO 8'h3f
`define LSR_ADDR_DOK_HI 8'h40
`define LSR_ADDR_DOK_LO 8'h41
`define LSR_ADDR_HDOK_HI 8'h42
`define LSR_ADDR_HDOK_LO 8'h43

// Field widths.
`define LSR_CHANNELS 10
`define LSR_GEN_FAULTS 12
`define LSR_SINK_W 6

// Reset values.
`define LSR_EN_RESET 10'h3ff
`define LSR_SINK_RESET 6'h1f

// Cycles after reset before the synchronised straps are trusted.
`define LSR_SETTLE_CYCLES 3'h4

`endif

// [lsr_pkg.sv]
// Types shared by the LED status register bank.
`default_nettype none

package lsr_pkg;

  // Startup sequencing states.
  typedef enum logic [1:0] {
    lsr_st_settle,
    lsr_st_check,
    lsr_st_run,
    lsr_st_blocked
  } lsr_state_type;

endpackage : lsr_pkg

`default_nettype wire

// [lsr_regs.sv]
// LED driver status, sink level and channel enable register bank with its helpers.
//
// Function
// R1: Channels 8-10 sink level, six bits, reset 0x1f.
// R2: Twelve live general faults, read-only high/low pair.
// R3: Live in-regulation flags, ten channels, read-only.
// R4: Live pin-to-ground short flags, ten channels, read-only.
// R5: Live drive-OK flags, ten channels, read-only.
// R6: Held bits stay set; written one clears.
// R7: Held in-regulation copies for ten channels.
// R8: Held pin-to-ground short flags for ten channels.
// R9: Held string short flags for ten channels.
// R10: Held drive-OK flags, cleared by written one.
// R11: Enable value spans two bytes, high first.
// R12: Enable bits 9,8 drive channels 10,9; reset one.
// R13: Unpopulated yet enabled channel blocks startup, flags fault.
// R14: Enable bits 7-0 drive channels 8-1; reset one.
// R15: Unused bits read zero, writes there ignored.
// R16: Held bits latch same cycle; set beats clear.
`include "lsr_defs.svh"
`default_nettype none

// Three-stage synchroniser; the filtered value moves only when stages two and three agree.
module lsr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] filt,
  output logic [W-1:0] next_filt
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Stage one feeds only stage two, so no logic sees a metastable value.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end

  // Each bit takes the agreed value and otherwise holds.
  assign next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
endmodule : lsr_sync

// A bank of held flags, set by a live condition and cleared by writing ones.
module lsr_held #(
  parameter int W = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clear_in,
  output logic [W-1:0] held
);
  logic [W-1:0] next_held;

  // The set term is ORed last so an event in the clearing cycle survives.
  assign next_held = (held & ~clear_in) | set_in; // [R6] [R16]

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end
endmodule : lsr_held

module lsr_regs
  import lsr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [11:0] general_fault_in,
  input wire logic [9:0] in_band_in,
  input wire logic [9:0] pin_ground_in,
  input wire logic [9:0] string_short_in,
  input wire logic [9:0] drive_ok_in,
  input wire logic [9:0] unpopulated_in,
  output logic [9:0] channel_enable,
  output logic [5:0] sink_level_ch8,
  output logic [5:0] sink_level_ch9,
  output logic [5:0] sink_level_ch10,
  output logic startup_done,
  output logic startup_fault
);
  logic [11:0] live_general_fault_flag;
  logic [11:0] next_general;
  logic [9:0] live_in_band_flag;
  logic [9:0] next_band;
  logic [9:0] live_pin_ground_short_flag;
  logic [9:0] next_gnd;
  logic [9:0] live_string_short_flag;
  logic [9:0] next_str;
  logic [9:0] live_drive_ok_flag;
  logic [9:0] next_dok;
  logic [9:0] unpopulated;
  logic [11:0] held_general_fault_flag;
  logic [9:0] held_in_band_flag;
  logic [9:0] held_pin_ground_short_flag;
  logic [9:0] held_string_short_flag;
  logic [9:0] held_drive_ok_flag;
  lsr_state_type state;
  lsr_state_type next_state;
  logic [2:0] settle_count;
  logic enable_conflict;
  logic [7:0] next_rdata;

  // Analog detector outputs arrive unsynchronised, so each group is filtered.
  lsr_sync #(.W(`LSR_GEN_FAULTS)) u_sync_gen (
    .clk(clk),
    .resetn(resetn),
    .async_in(general_fault_in),
    .filt(live_general_fault_flag),
    .next_filt(next_general)
  ); // [R2]
  lsr_sync #(.W(`LSR_CHANNELS)) u_sync_band (
    .clk(clk),
    .resetn(resetn),
    .async_in(in_band_in),
    .filt(live_in_band_flag),
    .next_filt(next_band)
  ); // [R3]
  lsr_sync #(.W(`LSR_CHANNELS)) u_sync_gnd (
    .clk(clk),
    .resetn(resetn),
    .async_in(pin_ground_in),
    .filt(live_pin_ground_short_flag),
    .next_filt(next_gnd)
  ); // [R4]
  lsr_sync #(.W(`LSR_CHANNELS)) u_sync_str (
    .clk(clk),
    .resetn(resetn),
    .async_in(string_short_in),
    .filt(live_string_short_flag),
    .next_filt(next_str)
  );
  lsr_sync #(.W(`LSR_CHANNELS)) u_sync_dok (
    .clk(clk),
    .resetn(resetn),
    .async_in(drive_ok_in),
    .filt(live_drive_ok_flag),
    .next_filt(next_dok)
  ); // [R5]
  lsr_sync #(.W(`LSR_CHANNELS)) u_sync_strap (
    .clk(clk),
    .resetn(resetn),
    .async_in(unpopulated_in),
    .filt(unpopulated),
    .next_filt()
  );

  // Write strobes per register.
  wire wr_en_hi = reg_wr && (reg_addr == `LSR_ADDR_EN_HI);
  wire wr_en_lo = reg_wr && (reg_addr == `LSR_ADDR_EN_LO);
  wire wr_sink8 = reg_wr && (reg_addr == `LSR_ADDR_SINK8);
  wire wr_sink9 = reg_wr && (reg_addr == `LSR_ADDR_SINK9);
  wire wr_sink10 = reg_wr && (reg_addr == `LSR_ADDR_SINK10);
  wire wr_hgen_hi = reg_wr && (reg_addr == `LSR_ADDR_HGEN_HI);
  wire wr_hgen_lo = reg_wr && (reg_addr == `LSR_ADDR_HGEN_LO);
  wire wr_hband_hi = reg_wr && (reg_addr == `LSR_ADDR_HBAND_HI);
  wire wr_hband_lo = reg_wr && (reg_addr == `LSR_ADDR_HBAND_LO);
  wire wr_hgnd_hi = reg_wr && (reg_addr == `LSR_ADDR_HGND_HI);
  wire wr_hgnd_lo = reg_wr && (reg_addr == `LSR_ADDR_HGND_LO);
  wire wr_hstr_hi = reg_wr && (reg_addr == `LSR_ADDR_HSTR_HI);
  wire wr_hstr_lo = reg_wr && (reg_addr == `LSR_ADDR_HSTR_LO);
  wire wr_hdok_hi = reg_wr && (reg_addr == `LSR_ADDR_HDOK_HI);
  wire wr_hdok_lo = reg_wr && (reg_addr == `LSR_ADDR_HDOK_LO);

  // Clear masks keep only implemented bit positions, so unused bits never matter.
  wire [11:0] clr_gen = {wr_hgen_hi ? reg_wdata[3:0] : 4'h0,
                         wr_hgen_lo ? reg_wdata : 8'h00}; // [R6] [R15]
  wire [9:0] clr_band = {wr_hband_hi ? reg_wdata[1:0] : 2'h0,
                         wr_hband_lo ? reg_wdata : 8'h00}; // [R7]
  wire [9:0] clr_gnd = {wr_hgnd_hi ? reg_wdata[1:0] : 2'h0,
                        wr_hgnd_lo ? reg_wdata : 8'h00}; // [R8]
  wire [9:0] clr_str = {wr_hstr_hi ? reg_wdata[1:0] : 2'h0,
                        wr_hstr_lo ? reg_wdata : 8'h00}; // [R9]
  wire [9:0] clr_dok = {wr_hdok_hi ? reg_wdata[1:0] : 2'h0,
                        wr_hdok_lo ? reg_wdata : 8'h00}; // [R10]

  // Held banks take the next live value so they latch in the same edge as the live flag.
  lsr_held #(.W(`LSR_GEN_FAULTS)) u_held_gen (
    .clk(clk),
    .resetn(resetn),
    .set_in(next_general),
    .clear_in(clr_gen),
    .held(held_general_fault_flag)
  ); // [R6] [R16]
  lsr_held #(.W(`LSR_CHANNELS)) u_held_band (
    .clk(clk),
    .resetn(resetn),
    .set_in(next_band),
    .clear_in(clr_band),
    .held(held_in_band_flag)
  ); // [R7]
  lsr_held #(.W(`LSR_CHANNELS)) u_held_gnd (
    .clk(clk),
    .resetn(resetn),
    .set_in(next_gnd),
    .clear_in(clr_gnd),
    .held(held_pin_ground_short_flag)
  ); // [R8]
  lsr_held #(.W(`LSR_CHANNELS)) u_held_str (
    .clk(clk),
    .resetn(resetn),
    .set_in(next_str),
    .clear_in(clr_str),
    .held(held_string_short_flag)
  ); // [R9]
  lsr_held #(.W(`LSR_CHANNELS)) u_held_dok (
    .clk(clk),
    .resetn(resetn),
    .set_in(next_dok),
    .clear_in(clr_dok),
    .held(held_drive_ok_flag)
  ); // [R10]

  // Enable and sink level writes; only the documented field bits are stored.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      channel_enable <= `LSR_EN_RESET; // [R12] [R14]
      sink_level_ch8 <= `LSR_SINK_RESET; // [R1]
      sink_level_ch9 <= `LSR_SINK_RESET;
      sink_level_ch10 <= `LSR_SINK_RESET;
    end else begin
      if (wr_en_hi) begin
        channel_enable[9:8] <= reg_wdata[1:0]; // [R11] [R12] [R15]
      end
      if (wr_en_lo) begin
        channel_enable[7:0] <= reg_wdata; // [R14]
      end
      if (wr_sink8) begin
        sink_level_ch8 <= reg_wdata[5:0]; // [R1]
      end
      if (wr_sink9) begin
        sink_level_ch9 <= reg_wdata[5:0];
      end
      if (wr_sink10) begin
        sink_level_ch10 <= reg_wdata[5:0];
      end
    end
  end

  // Read bytes; the bits above each field are tied low so unused positions read zero.
  wire [7:0] rd_en_hi = {6'h00, channel_enable[9:8]}; // [R11] [R15]
  wire [7:0] rd_en_lo = channel_enable[7:0];
  wire [7:0] rd_sink8 = {2'h0, sink_level_ch8}; // [R1] [R15]
  wire [7:0] rd_sink9 = {2'h0, sink_level_ch9};
  wire [7:0] rd_sink10 = {2'h0, sink_level_ch10};
  wire [7:0] rd_gen_hi = {4'h0, live_general_fault_flag[11:8]}; // [R2]
  wire [7:0] rd_gen_lo = live_general_fault_flag[7:0];
  wire [7:0] rd_band_hi = {6'h00, live_in_band_flag[9:8]}; // [R3]
  wire [7:0] rd_band_lo = live_in_band_flag[7:0];
  wire [7:0] rd_gnd_hi = {6'h00, live_pin_ground_short_flag[9:8]}; // [R4]
  wire [7:0] rd_gnd_lo = live_pin_ground_short_flag[7:0];
  wire [7:0] rd_str_hi = {6'h00, live_string_short_flag[9:8]};
  wire [7:0] rd_str_lo = live_string_short_flag[7:0];
  wire [7:0] rd_hgen_hi = {4'h0, held_general_fault_flag[11:8]}; // [R6]
  wire [7:0] rd_hgen_lo = held_general_fault_flag[7:0];
  wire [7:0] rd_hband_hi = {6'h00, held_in_band_flag[9:8]}; // [R7]
  wire [7:0] rd_hband_lo = held_in_band_flag[7:0];
  wire [7:0] rd_hgnd_hi = {6'h00, held_pin_ground_short_flag[9:8]}; // [R8]
  wire [7:0] rd_hgnd_lo = held_pin_ground_short_flag[7:0];
  wire [7:0] rd_hstr_hi = {6'h00, held_string_short_flag[9:8]}; // [R9]
  wire [7:0] rd_hstr_lo = held_string_short_flag[7:0];
  wire [7:0] rd_dok_hi = {6'h00, live_drive_ok_flag[9:8]}; // [R5]
  wire [7:0] rd_dok_lo = live_drive_ok_flag[7:0];
  wire [7:0] rd_hdok_hi = {6'h00, held_drive_ok_flag[9:8]}; // [R10]
  wire [7:0] rd_hdok_lo = held_drive_ok_flag[7:0];

  // Read selection; an unmapped offset reads zero rather than a stale byte.
  assign next_rdata =
    (reg_addr == `LSR_ADDR_EN_HI) ? rd_en_hi :
    (reg_addr == `LSR_ADDR_EN_LO) ? rd_en_lo :
    (reg_addr == `LSR_ADDR_SINK8) ? rd_sink8 :
    (reg_addr == `LSR_ADDR_SINK9) ? rd_sink9 :
    (reg_addr == `LSR_ADDR_SINK10) ? rd_sink10 :
    (reg_addr == `LSR_ADDR_GEN_HI) ? rd_gen_hi :
    (reg_addr == `LSR_ADDR_GEN_LO) ? rd_gen_lo :
    (reg_addr == `LSR_ADDR_BAND_HI) ? rd_band_hi :
    (reg_addr == `LSR_ADDR_BAND_LO) ? rd_band_lo :
    (reg_addr == `LSR_ADDR_GND_HI) ? rd_gnd_hi :
    (reg_addr == `LSR_ADDR_GND_LO) ? rd_gnd_lo :
    (reg_addr == `LSR_ADDR_STR_HI) ? rd_str_hi :
    (reg_addr == `LSR_ADDR_STR_LO) ? rd_str_lo :
    (reg_addr == `LSR_ADDR_HGEN_HI) ? rd_hgen_hi :
    (reg_addr == `LSR_ADDR_HGEN_LO) ? rd_hgen_lo :
    (reg_addr == `LSR_ADDR_HBAND_HI) ? rd_hband_hi :
    (reg_addr == `LSR_ADDR_HBAND_LO) ? rd_hband_lo :
    (reg_addr == `LSR_ADDR_HGND_HI) ? rd_hgnd_hi :
    (reg_addr == `LSR_ADDR_HGND_LO) ? rd_hgnd_lo :
    (reg_addr == `LSR_ADDR_HSTR_HI) ? rd_hstr_hi :
    (reg_addr == `LSR_ADDR_HSTR_LO) ? rd_hstr_lo :
    (reg_addr == `LSR_ADDR_DOK_HI) ? rd_dok_hi :
    (reg_addr == `LSR_ADDR_DOK_LO) ? rd_dok_lo :
    (reg_addr == `LSR_ADDR_HDOK_HI) ? rd_hdok_hi :
    (reg_addr == `LSR_ADDR_HDOK_LO) ? rd_hdok_lo :
    8'h00; // [R15]

  // Read data is registered so the bus sees a steady byte one cycle after the strobe.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // An unpopulated channel left enabled stops startup.
  assign enable_conflict = |(unpopulated & channel_enable); // [R13]

  // Startup waits for the strap filters to settle before it judges the straps.
  // The blocked state rechecks every cycle, so correcting the enables lets startup go on.
  always_comb begin
    next_state = state;
    case (state)
      lsr_st_settle: begin
        if (settle_count == `LSR_SETTLE_CYCLES) begin
          next_state = lsr_st_check;
        end
      end
      lsr_st_check: begin
        next_state = enable_conflict ? lsr_st_blocked : lsr_st_run; // [R13]
      end
      lsr_st_run: begin
        next_state = lsr_st_run;
      end
      lsr_st_blocked: begin
        next_state = enable_conflict ? lsr_st_blocked : lsr_st_run; // [R13]
      end
      default: begin
        next_state = lsr_st_settle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= lsr_st_settle;
      settle_count <= 3'h0;
      startup_done <= 1'b0;
      startup_fault <= 1'b0;
    end else begin
      state <= next_state;
      if (state == lsr_st_settle) begin
        settle_count <= settle_count + 3'h1;
      end
      startup_done <= (next_state == lsr_st_run);
      startup_fault <= (next_state == lsr_st_blocked); // [R13]
    end
  end
endmodule : lsr_regs

`default_nettype wire

// [lsr_regs_props.sv]
// Port checker of the LED status register bank.
`default_nettype none
module lsr_regs_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [9:0] channel_enable,
  input wire logic [9:0] unpopulated_in,
  input wire logic [5:0] sink_level_ch8,
  input wire logic [5:0] sink_level_ch10,
  input wire logic startup_done,
  input wire logic startup_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // Everything here lives in the one register clock domain.
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_sink_wr;
    reg_wr && reg_addr == 8'h2d |=> sink_level_ch8 == $past(reg_wdata[5:0]);
  endproperty
  a_sink_wr: assert property (p_sink_wr) else $error("sink level ch8 not written");
  property p_sink_rd;
    reg_rd && reg_addr == 8'h2f |=> reg_rdata == {2'h0, $past(sink_level_ch10)};
  endproperty
  a_sink_rd: assert property (p_sink_rd) else $error("sink level ch10 read wrong");
  property p_en_hi;
    reg_wr && reg_addr == 8'h00 |=> channel_enable[9:8] == $past(reg_wdata[1:0]);
  endproperty
  a_en_hi: assert property (p_en_hi) else $error("upper enable not written");
  property p_en_lo;
    reg_wr && reg_addr == 8'h01 |=> channel_enable[7:0] == $past(reg_wdata);
  endproperty
  a_en_lo: assert property (p_en_lo) else $error("lower enable not written");
  property p_en_keep;
    !(reg_wr && reg_addr[7:1] == 7'h00) |=> $stable(channel_enable);
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("enable moved without write");
  property p_rd_lo;
    reg_rd && reg_addr == 8'h01 |=> reg_rdata == $past(channel_enable[7:0]);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("lower enable read wrong");
  property p_rd_hi;
    reg_rd && reg_addr == 8'h00 |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("unused enable bits not zero");
  property p_unmapped;
    reg_rd && reg_addr == 8'h50 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // A refusal needs an enabled channel strapped unpopulated; straps stay put while held.
  property p_startup;
    startup_fault |-> !startup_done && (|($past(unpopulated_in) & $past(channel_enable)));
  endproperty
  a_startup: assert property (p_startup) else $error("startup done while refused");
endmodule : lsr_regs_props

bind lsr_regs lsr_regs_props i_props (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .channel_enable(channel_enable), .unpopulated_in(unpopulated_in),
  .sink_level_ch8(sink_level_ch8),
  .sink_level_ch10(sink_level_ch10), .startup_done(startup_done),
  .startup_fault(startup_fault));
`default_nettype wire

// [lsr_host.sv]
// Host model that reaches the register bank through its byte port.
`default_nettype none
module lsr_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write strobe; ones written to a held byte clear those bits.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a; // Parked on the inverse so a stale address cannot pass.
    reg_wdata <= ~d;
  endtask : wr
  // One read strobe; the data stands from the edge that took it.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : lsr_host
`default_nettype wire

// [lsr_regs_tb.sv]
// Self-checking bench of the LED status register bank.
`default_nettype none
module lsr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] LIVE_A [10] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36,
    8'h37, 8'h40, 8'h41};
  localparam logic [7:0] HELD_A [10] = '{8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e,
    8'h3f, 8'h42, 8'h43};
  localparam logic [7:0] PAT [10] = '{8'h0a, 8'h5c, 8'h02, 8'ha5, 8'h01, 8'h5a, 8'h03,
    8'h01, 8'h00, 8'hff};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic reg_wr, reg_rd, startup_done, startup_fault;
  logic [11:0] gen_in = 12'h000;
  logic [9:0] band_in = 10'h000, gnd_in = 10'h000, str_in = 10'h000, dok_in = 10'h000;
  logic [9:0] unpop_in = 10'h008;
  logic [9:0] channel_enable;
  logic [5:0] sink8, sink9, sink10;
  int miscompares = 0;
  int num_checks = 0;
  // The 25 MHz register clock.
  always #20 clk = ~clk;
  lsr_host i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  lsr_regs i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .general_fault_in(gen_in),
    .in_band_in(band_in), .pin_ground_in(gnd_in), .string_short_in(str_in),
    .drive_ok_in(dok_in), .unpopulated_in(unpop_in), .channel_enable(channel_enable),
    .sink_level_ch8(sink8), .sink_level_ch9(sink9), .sink_level_ch10(sink10),
    .startup_done(startup_done), .startup_fault(startup_fault));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // Reset values, then a channel strapped unpopulated but enabled holds startup back.
  task automatic test_startup;
    i_host.rd(8'h00, rd);
    chk(rd, 8'h03);
    i_host.rd(8'h01, rd);
    chk(rd, 8'hff);
    chk({sink8, sink10}, 12'h7df);
    chk({startup_done, startup_fault}, 2'b01);
    i_host.wr(8'h01, 8'hf7);
    repeat (4) @(posedge clk);
    chk(channel_enable, 10'h3f7);
    chk({startup_done, startup_fault}, 2'b10);
    unpop_in <= 10'h000;
    $display("startup test done");
  endtask : test_startup
  // Writes with unused bits set, read-only and unmapped places.
  task automatic test_rw;
    i_host.wr(8'h00, 8'hfe);
    i_host.rd(8'h00, rd);
    chk(rd, 8'h02);
    chk(channel_enable, 10'h2f7);
    for (int i = 0; i < 3; i++) begin
      i_host.wr(8'h2d + 8'(i), 8'hc5 + 8'(i));
      i_host.rd(8'h2d + 8'(i), rd);
      chk(rd, 8'h05 + 8'(i));
    end
    chk(sink9, 6'h06);
    i_host.wr(8'h30, 8'hff);
    i_host.rd(8'h30, rd);
    chk(rd, 8'h00);
    i_host.wr(8'h50, 8'hff);
    i_host.rd(8'h50, rd);
    chk(rd, 8'h00);
    $display("register test done");
  endtask : test_rw
  // Live flags follow inputs; held copies stay until a one is written with the input gone.
  task automatic test_flags;
    {gen_in, band_in, gnd_in, str_in, dok_in} <= {12'ha5c, 10'h2a5, 10'h15a, 10'h301, 10'h0ff};
    repeat (6) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      i_host.rd(LIVE_A[i], rd);
      chk(rd, PAT[i]);
      i_host.rd(HELD_A[i], rd);
      chk(rd, PAT[i]);
    end
    i_host.wr(8'h3d, 8'hff);
    i_host.rd(8'h3d, rd);
    chk(rd, 8'h5a);
    {gen_in, band_in, gnd_in, str_in, dok_in} <= '0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      i_host.rd(LIVE_A[i], rd);
      chk(rd, 8'h00);
      i_host.wr(HELD_A[i], 8'h00);
      i_host.rd(HELD_A[i], rd);
      chk(rd, PAT[i]);
      i_host.wr(HELD_A[i], 8'hff);
      i_host.rd(HELD_A[i], rd);
      chk(rd, 8'h00);
    end
    $display("flag test done");
  endtask : test_flags
  // Main sequence after twelve cycles of reset.
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    test_startup();
    test_rw();
    test_flags();
    print_verdict();
  end
  // A hang is cut short well beyond the expected run.
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule : lsr_regs_tb
`default_nettype wire
